// [ubd_pkg.sv]
/*
 * Constants shared by the bulk DMA block: register indices, field positions,
 * reset values, packet and queue sizes, serial bit timing.
 * Assumes a 250 MHz mclk and a 1 ms start-of-frame pulse from the USB side.
 */
package ubd_pkg;
    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam int          UBD_AW        = 18;
    localparam logic [15:0] UBD_IDX_RDR   = 16'hffa0;
    localparam logic [15:0] UBD_IDX_TDR   = 16'hffa1;
    localparam logic [15:0] UBD_IDX_CTRL  = 16'hffe0;
    localparam logic [15:0] UBD_IDX_TMO   = 16'hffe1;
    localparam logic [15:0] UBD_IDX_IST   = 16'hffe2;
    localparam logic [15:0] UBD_IDX_IMASK = 16'hffe3;
    localparam logic [15:0] UBD_IDX_DESC  = 16'hffe4;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int UBD_CTRL_EN    = 0;
    localparam int UBD_CTRL_CONT  = 1;
    localparam int UBD_CTRL_DIR   = 2;
    localparam int UBD_CTRL_DESC  = 3;
    localparam int UBD_TMO_OVERRUN_FLAG  = 0;
    localparam int UBD_TMO_TIMEOUT_FLAG   = 1;
    localparam int UBD_TMO_C      = 2;
    localparam int UBD_TMO_TEN    = 7;
    localparam int UBD_TMO_PARTIAL_PACKET_FLAG   = 8;
    localparam int UBD_EV_STOP    = 0;
    localparam int UBD_EV_PART    = 1;
    localparam int UBD_EV_LINE    = 2;
    // ------------------------------------------------------------------
    // Reset values and sizes
    // ------------------------------------------------------------------
    localparam logic [7:0] UBD_RST_BYTE  = 8'h00;
    localparam logic [6:0] UBD_PKT_BYTES = 7'h40;
    localparam int         UBD_RXQ_DEPTH = 32;
    // ------------------------------------------------------------------
    // Serial bit timing
    // ------------------------------------------------------------------
    localparam int UBD_CLK_HZ   = 250_000_000;
    localparam int UBD_BAUD_HZ  = 115_200;
    localparam int UBD_BIT_CLKS = UBD_CLK_HZ / UBD_BAUD_HZ;
endpackage

// [ubd_top.sv]
/*
 * Bulk DMA between a double-buffered USB endpoint and a serial port:
 * buffer manager, DMA engine with time-out, 8N1 receiver with queue,
 * double-buffered transmitter, APB register slave, interrupt.
 * Assumes sofPulse and the usb* ports come from logic on mclk.
 */
// Our own choice: the APB slave port.
// What this block does
// - DMA starts moving data once the enable bit is one.
// - IN: after 64 bytes, record count and clear that buffer's NAK.
// - Manager sends ready buffer, toggles X/Y; DMA fills the other.
// - IN time-out with partial buffer: time-out set, overrun clear, interrupt.
// - IN time-out with both buffers full: stop, both flags set, interrupt.
// - Receiver error in IN direction with enable set stops DMA, time-out set, no DMA interrupt.
// - OUT: after 64 host bytes, manager records count and sets NAK.
// - DMA empties ready OUT buffers into transmitter, alternating X/Y.
// - Short host packet: send it, clear time-out, set partial, interrupt.
// - OUT time-out with both buffers empty: stop, time-out set, interrupt.
// - Receiver turns serial bits into bytes in a 32-entry queue.
// - Receive register pops one byte per read; reads zero when empty.
// - Transmit register is double buffered ahead of the shifter.
// - Firmware and DMA may both use receive and transmit registers.
// - Time-out counter reloads per byte, counts down per frame pulse.
// - Overrun and time-out flags clear on a written one; hardware also clears overrun, short packets clear time-out.
`timescale 1ns/1ps
module ubd_top
    import ubd_pkg::*;
#(
    parameter int BIT_CLKS = UBD_BIT_CLKS
)(
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [UBD_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              sofPulse,
    input  wire logic              serialInputLine,
    output logic                   serialOutputLine,
    output logic      [7:0]        usbInData,
    output logic                   usbInValid,
    output logic                   usbInLast,
    input  wire logic              usbInTake,
    input  wire logic [7:0]        usbOutData,
    input  wire logic              usbOutWrite,
    input  wire logic              usbOutEnd,
    output logic                   usbOutReady,
    output logic                   irq
);
    if (BIT_CLKS < 4 || BIT_CLKS > 65535) begin : gBadBits
        $error("BIT_CLKS out of range");
    end

    localparam logic [15:0] BITC  = 16'(BIT_CLKS - 1);
    localparam logic [15:0] HALFC = 16'(BIT_CLKS / 2);
    localparam logic [5:0]  QFULL = 6'(UBD_RXQ_DEPTH);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic             en, cont, dirOut, timeout_counter_enable, overrun_flag, timeout_flag, partial_packet_flag, cur, bsel, started;
        logic             rxBusy, txFull, txBusy, serOut, pready, pslverr, irq;
        logic             inValid, inLast, outReady;
        logic [2:0]       desc, ist, imask;
        logic [4:0]       tmo, tmr;
        logic [1:0]       nak, rxSync;
        logic [1:0][6:0]  cnt;
        logic [6:0]       dptr, bptr;
        logic [15:0]      rxDiv, txDiv;
        logic [3:0]       rxBit, txBit;
        logic [7:0]       rxSh, txHold, inData;
        logic [5:0]       wp, rp;
        logic [9:0]       txSh;
        logic [31:0]      prdata;
    } ubd_st_type;

    ubd_st_type s_r, s_nxt;
    logic [7:0] pktRam [0:127];
    logic [7:0] rxMem  [0:UBD_RXQ_DEPTH-1];
    logic       ramWe, push;
    logic [6:0] ramA;
    logic [7:0] ramD;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic       setup, acc, wr, rd, map;
        logic [15:0] idx;
        logic [5:0] lvl;
        logic       qEmpty, fwPop, fwTx, run, moved, expire;
        logic [2:0] ev;
        logic       setTo, setOv, clrOv, clrTo, setPp;
        logic [7:0] head;
        s_nxt  = s_r;
        setup  = psel & ~penable;
        acc    = psel & penable & s_r.pready;
        wr     = acc & pwrite;
        rd     = acc & ~pwrite;
        idx    = paddr[17:2];
        map    = idx inside {UBD_IDX_RDR, UBD_IDX_TDR, UBD_IDX_CTRL, UBD_IDX_TMO, UBD_IDX_IST,
                             UBD_IDX_IMASK, UBD_IDX_DESC};
        lvl    = s_r.wp - s_r.rp;
        qEmpty = (lvl == 6'd0);
        head   = qEmpty ? UBD_RST_BYTE : rxMem[s_r.rp[4:0]];
        fwPop  = rd & (idx == UBD_IDX_RDR) & ~qEmpty;
        fwTx   = wr & (idx == UBD_IDX_TDR) & ~s_r.txFull;
        run    = s_r.en & ~s_r.timeout_flag;
        moved  = 1'b0;
        expire = 1'b0;
        ev     = 3'b000;
        setTo  = 1'b0;
        setOv  = 1'b0;
        clrOv  = 1'b0;
        clrTo  = 1'b0;
        setPp  = 1'b0;
        push   = 1'b0;
        ramWe  = 1'b0;
        ramA   = 7'd0;
        ramD   = pwdata[7:0];

        // APB answer, one access cycle
        s_nxt.pready  = setup;
        s_nxt.pslverr = setup & ~map;
        if (setup) begin
            case (idx)
                UBD_IDX_RDR:   s_nxt.prdata = {24'd0, head};
                UBD_IDX_CTRL:  s_nxt.prdata = {26'd0, s_r.desc, s_r.dirOut, s_r.cont, s_r.en};
                UBD_IDX_TMO:   s_nxt.prdata = {23'd0, s_r.partial_packet_flag, s_r.timeout_counter_enable, s_r.tmo, s_r.timeout_flag,
                                               s_r.overrun_flag};
                UBD_IDX_IST:   s_nxt.prdata = {29'd0, s_r.ist};
                UBD_IDX_IMASK: s_nxt.prdata = {29'd0, s_r.imask};
                UBD_IDX_DESC:  s_nxt.prdata = {8'd0, lvl, s_r.nak, 1'b0, s_r.cnt[1], 1'b0,
                                               s_r.cnt[0]};
                default:       s_nxt.prdata = 32'h0000_0000;
            endcase
        end

        // Receiver, two-flop synchroniser then 8N1 sampler
        s_nxt.rxSync = {s_r.rxSync[0], serialInputLine};
        if (!s_r.rxBusy) begin
            if (!s_r.rxSync[1]) begin
                s_nxt.rxBusy = 1'b1;
                s_nxt.rxDiv  = HALFC;
                s_nxt.rxBit  = 4'd0;
            end
        end else if (s_r.rxDiv != 16'd0) begin
            s_nxt.rxDiv = s_r.rxDiv - 16'd1;
        end else begin
            s_nxt.rxDiv = BITC;
            s_nxt.rxBit = s_r.rxBit + 4'd1;
            if (s_r.rxBit == 4'd0) begin
                s_nxt.rxBusy = ~s_r.rxSync[1];
            end else if (s_r.rxBit != 4'd9) begin
                s_nxt.rxSh = {s_r.rxSync[1], s_r.rxSh[7:1]};
            end else begin
                s_nxt.rxBusy = 1'b0;
                if (s_r.rxSync[1]) begin
                    push = (lvl != QFULL);
                end else begin
                    ev[UBD_EV_LINE] = 1'b1;
                    if (s_r.en && !s_r.dirOut) begin
                        setTo = 1'b1;
                        clrOv = 1'b1;
                    end
                end
            end
        end

        // Transmitter: holding register feeds the shifter
        if (!s_r.txBusy) begin
            if (s_r.txFull) begin
                s_nxt.txSh   = {1'b1, s_r.txHold, 1'b0};
                s_nxt.serOut = 1'b0;
                s_nxt.txBusy = 1'b1;
                s_nxt.txFull = 1'b0;
                s_nxt.txBit  = 4'd0;
                s_nxt.txDiv  = BITC;
            end
        end else if (s_r.txDiv != 16'd0) begin
            s_nxt.txDiv = s_r.txDiv - 16'd1;
        end else if (s_r.txBit == 4'd9) begin
            s_nxt.txBusy = 1'b0;
        end else begin
            s_nxt.txSh   = {1'b1, s_r.txSh[9:1]};
            s_nxt.serOut = s_r.txSh[1];
            s_nxt.txBit  = s_r.txBit + 4'd1;
            s_nxt.txDiv  = BITC;
        end
        if (fwTx) begin
            s_nxt.txHold = pwdata[7:0];
            s_nxt.txFull = 1'b1;
        end

        // DMA engine
        if (run && !s_r.dirOut) begin
            if (s_r.nak[s_r.cur] && !qEmpty && !fwPop
                && !(psel && idx == UBD_IDX_RDR)) begin
                moved = 1'b1;
                ramWe = 1'b1;
                ramA  = {s_r.cur, s_r.dptr[5:0]};
                ramD  = head;
                s_nxt.dptr = s_r.dptr + 7'd1;
                if (s_r.dptr == UBD_PKT_BYTES - 7'd1) begin
                    s_nxt.cnt[s_r.cur] = UBD_PKT_BYTES;
                    s_nxt.nak[s_r.cur] = 1'b0;
                    s_nxt.cur  = ~s_r.cur;
                    s_nxt.dptr = 7'd0;
                end
            end
        end else if (run && s_r.nak[s_r.cur] && !s_r.txFull && !fwTx) begin
            moved = 1'b1;
            s_nxt.txHold = pktRam[{s_r.cur, s_r.dptr[5:0]}];
            s_nxt.txFull = 1'b1;
            s_nxt.dptr   = s_r.dptr + 7'd1;
            if (s_r.dptr + 7'd1 >= s_r.cnt[s_r.cur]) begin
                s_nxt.nak[s_r.cur] = 1'b0;
                s_nxt.cur  = ~s_r.cur;
                s_nxt.dptr = 7'd0;
                if (s_r.cnt[s_r.cur] < UBD_PKT_BYTES) begin
                    clrTo = 1'b1;
                    setPp = 1'b1;
                    ev[UBD_EV_PART] = 1'b1;
                end
            end
        end
        if (fwPop || (moved && !s_r.dirOut))
            s_nxt.rp = s_r.rp + 6'd1;
        s_nxt.wp = s_r.wp + 6'(push);

        // Transaction timer
        if (moved) begin
            s_nxt.tmr     = s_r.tmo;
            s_nxt.started = 1'b1;
        end else if (sofPulse && run && s_r.timeout_counter_enable && s_r.started) begin
            if (s_r.tmr <= 5'd1)
                expire = 1'b1;
            else
                s_nxt.tmr = s_r.tmr - 5'd1;
        end
        if (expire) begin
            s_nxt.started = 1'b0;
            setTo = 1'b1;
            ev[UBD_EV_STOP] = 1'b1;
            if (s_r.dirOut) begin
                clrOv = 1'b1;
            end else if (s_r.nak[s_r.cur] && s_r.dptr != 7'd0) begin
                clrOv = 1'b1;
                s_nxt.cnt[s_r.cur] = s_r.dptr;
                s_nxt.nak[s_r.cur] = 1'b0;
                s_nxt.cur  = ~s_r.cur;
                s_nxt.dptr = 7'd0;
            end else if (s_r.nak == 2'b00) begin
                setOv = 1'b1;
            end else begin
                clrOv = 1'b1;
            end
        end

        // Buffer manager, USB side
        s_nxt.inValid = 1'b0;
        if (!s_r.dirOut) begin
            if (s_r.inValid && usbInTake) begin
                s_nxt.bptr = s_r.bptr + 7'd1;
                if (s_r.inLast) begin
                    s_nxt.nak[s_r.bsel] = 1'b1;
                    s_nxt.bsel = ~s_r.bsel;
                    s_nxt.bptr = 7'd0;
                end
            end else begin
                s_nxt.inValid = s_r.en && !s_r.nak[s_r.bsel]
                                && s_r.cnt[s_r.bsel] != 7'd0;
            end
            s_nxt.inData = pktRam[{s_r.bsel, s_r.bptr[5:0]}];
            s_nxt.inLast = s_nxt.inValid && (s_r.bptr + 7'd1 == s_r.cnt[s_r.bsel]);
        end else if (usbOutWrite && s_r.outReady) begin
            ramWe = 1'b1;
            ramA  = {s_r.bsel, s_r.bptr[5:0]};
            ramD  = usbOutData;
            s_nxt.bptr = s_r.bptr + 7'd1;
            if (usbOutEnd || s_r.bptr == UBD_PKT_BYTES - 7'd1) begin
                s_nxt.cnt[s_r.bsel] = s_r.bptr + 7'd1;
                s_nxt.nak[s_r.bsel] = 1'b1;
                s_nxt.bsel = ~s_r.bsel;
                s_nxt.bptr = 7'd0;
            end
        end
        s_nxt.outReady = s_r.dirOut && s_r.en && !s_nxt.nak[s_nxt.bsel];

        // Register writes; hardware sets win over software clears
        if (wr && idx == UBD_IDX_CTRL) begin
            s_nxt.en     = pwdata[UBD_CTRL_EN];
            s_nxt.cont   = pwdata[UBD_CTRL_CONT];
            s_nxt.desc   = pwdata[UBD_CTRL_DESC +: 3];
            if (pwdata[UBD_CTRL_DIR] != s_r.dirOut || !s_r.en) begin
                s_nxt.dirOut  = pwdata[UBD_CTRL_DIR];
                s_nxt.nak     = pwdata[UBD_CTRL_DIR] ? 2'b00 : 2'b11;
                s_nxt.cnt     = '0;
                s_nxt.cur     = 1'b0;
                s_nxt.bsel    = 1'b0;
                s_nxt.dptr    = 7'd0;
                s_nxt.bptr    = 7'd0;
                s_nxt.started = 1'b0;
                {s_nxt.inValid, s_nxt.inLast} = 2'b00;
                s_nxt.outReady = 1'b0;
            end
        end
        if (wr && idx == UBD_IDX_TMO) begin
            s_nxt.tmo = pwdata[UBD_TMO_C +: 5];
            s_nxt.timeout_counter_enable = pwdata[UBD_TMO_TEN];
        end
        if (wr && idx == UBD_IDX_IMASK)
            s_nxt.imask = pwdata[2:0];
        s_nxt.overrun_flag = setOv | (s_r.overrun_flag & ~clrOv
                      & ~(wr && idx == UBD_IDX_TMO && pwdata[UBD_TMO_OVERRUN_FLAG]));
        s_nxt.timeout_flag  = setTo | (s_r.timeout_flag & ~clrTo
                      & ~(wr && idx == UBD_IDX_TMO && pwdata[UBD_TMO_TIMEOUT_FLAG]));
        s_nxt.partial_packet_flag  = setPp | (s_r.partial_packet_flag
                      & ~(wr && idx == UBD_IDX_TMO && pwdata[UBD_TMO_PARTIAL_PACKET_FLAG]));
        s_nxt.ist   = ev | (s_r.ist & ~((wr && idx == UBD_IDX_IST) ? pwdata[2:0] : 3'b000));
        s_nxt.irq   = |(s_nxt.ist & s_nxt.imask);
    end

    // ------------------------------------------------------------------
    // Registers and memories
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_r        <= '0;
            s_r.nak    <= 2'b11;
            s_r.rxSync <= 2'b11;
            s_r.serOut <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (ramWe)
            pktRam[ramA] <= ramD;
        if (push)
            rxMem[s_r.wp[4:0]] <= s_r.rxSh;
    end

    assign prdata           = s_r.prdata;
    assign pready           = s_r.pready;
    assign pslverr          = s_r.pslverr;
    assign serialOutputLine = s_r.serOut;
    assign usbInData        = s_r.inData;
    assign usbInValid       = s_r.inValid;
    assign usbInLast        = s_r.inLast;
    assign usbOutReady      = s_r.outReady;
    assign irq              = s_r.irq;
endmodule // ubd_top

// [ubd_top_sva.sv]
/* Checker for the bulk DMA top: APB answer timing, IN offer handshake,
   serial bit timing. Assumes it is bound to ubd_top and sees only its ports. */
`timescale 1ns/1ps
module ubd_top_sva
    import ubd_pkg::*;
#(
    parameter int BIT_CLKS = UBD_BIT_CLKS
)(
    input wire logic              mclk,
    input wire logic              resetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [UBD_AW-1:0] paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              serialOutputLine,
    input wire logic [7:0]        usbInData,
    input wire logic              usbInValid,
    input wire logic              usbInLast,
    input wire logic              usbInTake
);
    logic        lineQ_r;
    int unsigned gapCnt_r;
    always_ff @(posedge mclk or negedge resetn)
        if (!resetn) lineQ_r <= 1'b1;
        else lineQ_r <= serialOutputLine;
    always_ff @(posedge mclk or negedge resetn)
        if (!resetn) gapCnt_r <= BIT_CLKS;
        else if (serialOutputLine != lineQ_r) gapCnt_r <= 0;
        else if (gapCnt_r < BIT_CLKS) gapCnt_r <= gapCnt_r + 1;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("answer held too long");
    a_error_reads_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("bad refused access");
    a_rdr_byte_only: assert property (pready && !pwrite && paddr == {UBD_IDX_RDR, 2'b00}
        |-> prdata[31:8] == 24'h00_0000)
        else $error("receive read too wide");
    a_offer_held: assert property (usbInValid && !usbInTake
        |=> usbInValid && $stable(usbInData) && $stable(usbInLast))
        else $error("offered byte lost");
    a_take_drops_valid: assert property (usbInValid && usbInTake |=> !usbInValid)
        else $error("valid kept after take");
    a_last_with_valid: assert property (usbInLast |-> usbInValid)
        else $error("last without valid");
    a_bit_time_held: assert property (serialOutputLine != lineQ_r
        |-> gapCnt_r >= BIT_CLKS - 1)
        else $error("serial bit too short");
    cover property (usbInTake && usbInLast);
    cover property (pslverr);
    cover property ($fell(serialOutputLine));
endmodule // ubd_top_sva

// [ubd_far_model.sv]
/* Far-side model: serial peer on both lines, USB host taking IN bytes and
   writing OUT packets. Assumes mclk is the block's clock. */
`timescale 1ns/1ps
module ubd_far_model #(
    parameter int BIT_CLKS = 8
)(
    input wire logic       mclk,
    output logic           serialInputLine,
    input wire logic       serialOutputLine,
    input wire logic [7:0] usbInData,
    input wire logic       usbInValid,
    input wire logic       usbInLast,
    output logic           usbInTake,
    output logic [7:0]     usbOutData,
    output logic           usbOutWrite,
    output logic           usbOutEnd,
    input wire logic       usbOutReady
);
    logic       stall;
    logic [7:0] inQ[$];
    logic [7:0] txQ[$];
    logic       lastQ[$];
    logic [7:0] b;
    initial
    begin
        serialInputLine = 1'b1;
        usbInTake = 1'b0;
        usbOutData = 8'h00;
        usbOutWrite = 1'b0;
        usbOutEnd = 1'b0;
        stall = 1'b0;
    end
    // Host takes offered bytes unless stalled
    always @(posedge mclk)
        if (usbInTake)
        begin
            inQ.push_back(usbInData);
            lastQ.push_back(usbInLast);
            usbInTake <= 1'b0;
        end
        else if (usbInValid === 1'b1 && !stall) usbInTake <= 1'b1;
    // Serial receiver on the block's output, mid-bit sampling
    initial forever
    begin
        @(negedge serialOutputLine);
        repeat (BIT_CLKS / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT_CLKS) @(posedge mclk);
            b[i] = serialOutputLine;
        end
        repeat (BIT_CLKS) @(posedge mclk);
        txQ.push_back(b);
    end
    task rxByte(input logic [7:0] d, input logic stopBit);
        logic [9:0] f;
        f = {stopBit, d, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            serialInputLine <= f[i];
            repeat (BIT_CLKS) @(posedge mclk);
        end
        serialInputLine <= 1'b1;
        repeat (BIT_CLKS) @(posedge mclk);
    endtask
    // Data bus shows a changed value once released
    task hostPkt(input int n, input logic [7:0] base);
        for (int i = 0; i < n; i++)
        begin
            @(posedge mclk);
            while (usbOutReady !== 1'b1) @(posedge mclk);
            usbOutData <= base + 8'(i);
            usbOutWrite <= 1'b1;
            usbOutEnd <= (i == n - 1) && (n < 64);
        end
        @(posedge mclk);
        usbOutWrite <= 1'b0;
        usbOutEnd <= 1'b0;
        usbOutData <= ~usbOutData;
    endtask
endmodule // ubd_far_model

// [usb_uart_bulk_dma_tb_top.sv]
/* Self-checking bench for ubd_top: APB master, frame pulses, far-side model.
   Assumes package, design, model and checker are compiled first. */
`timescale 1ns/1ps
module usb_uart_bulk_dma_tb_top;
    import ubd_pkg::*;
    localparam int BC = 8;
    logic              mclk, resetn, psel, penable, pwrite, sofPulse, serIn, serOut;
    logic [UBD_AW-1:0] paddr;
    logic [31:0]       pwdata, prdata, rdq;
    logic              pready, pslverr, inValid, inLast, inTake, outWrite, outEnd;
    logic              outReady, irq, rde;
    logic [7:0]        inData, outData;
    int                failCount, nTests;
    ubd_top #(.BIT_CLKS(BC)) ubd_top_i (.mclk(mclk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sofPulse(sofPulse), .serialInputLine(serIn),
        .serialOutputLine(serOut), .usbInData(inData), .usbInValid(inValid),
        .usbInLast(inLast), .usbInTake(inTake), .usbOutData(outData), .usbOutWrite(outWrite),
        .usbOutEnd(outEnd), .usbOutReady(outReady), .irq(irq));
    ubd_far_model #(.BIT_CLKS(BC)) ubd_far_model_i (.mclk(mclk), .serialInputLine(serIn),
        .serialOutputLine(serOut), .usbInData(inData), .usbInValid(inValid),
        .usbInLast(inLast), .usbInTake(inTake), .usbOutData(outData), .usbOutWrite(outWrite),
        .usbOutEnd(outEnd), .usbOutReady(outReady));
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp)
        begin
            failCount++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [15:0] idx, input logic [31:0] d = 32'h0000_0000);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rdq = prdata;
        rde = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task sof();
        @(posedge mclk);
        sofPulse <= 1'b1;
        @(posedge mclk);
        sofPulse <= 1'b0;
    endtask
    task waitQ(input int n, input logic tx);
        for (int k = 0; k < 20000; k++)
        begin
            if ((tx ? ubd_far_model_i.txQ.size() : ubd_far_model_i.inQ.size()) >= n) break;
            @(posedge mclk);
        end
    endtask
    task chkIn(input int n, input logic [7:0] base);
        waitQ(n, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            chk(32'(ubd_far_model_i.inQ.pop_front()), 32'(base + 8'(i)));
            chk(32'(ubd_far_model_i.lastQ.pop_front()), 32'(i == n - 1));
        end
    endtask
    task tRegs();
        apb(1'b0, UBD_IDX_RDR);
        chk(rdq, 32'h0000_0000);
        apb(1'b0, UBD_IDX_DESC);
        chk(32'(rdq[17:16]), 32'h0000_0003);
        apb(1'b0, 16'hff00);
        chk(32'(rde), 32'h0000_0001);
        ubd_far_model_i.rxByte(8'ha5, 1'b1);
        apb(1'b0, UBD_IDX_RDR);
        chk(rdq, 32'h0000_00a5);
        apb(1'b0, UBD_IDX_RDR);
        chk(rdq, 32'h0000_0000);
        apb(1'b1, UBD_IDX_TDR, 32'h0000_003c);
        apb(1'b1, UBD_IDX_TDR, 32'h0000_00c3);
        waitQ(2, 1'b1);
        chk(32'(ubd_far_model_i.txQ.pop_front()), 32'h0000_003c);
        chk(32'(ubd_far_model_i.txQ.pop_front()), 32'h0000_00c3);
        $display("test regs done");
    endtask
    task tIn();
        apb(1'b1, UBD_IDX_IMASK, 32'h0000_0007);
        apb(1'b1, UBD_IDX_TMO, 32'h0000_0088);
        apb(1'b1, UBD_IDX_CTRL, 32'h0000_0003);
        ubd_far_model_i.stall <= 1'b1;
        for (int i = 0; i < 64; i++) ubd_far_model_i.rxByte(8'(i), 1'b1);
        ubd_far_model_i.stall <= 1'b0;
        chkIn(64, 8'h00);
        for (int i = 0; i < 3; i++) ubd_far_model_i.rxByte(8'h80 + 8'(i), 1'b1);
        repeat (20) @(posedge mclk);
        sof();
        apb(1'b0, UBD_IDX_TMO);
        chk(32'(rdq[1:0]), 32'h0000_0000);
        sof();
        apb(1'b0, UBD_IDX_TMO);
        chk(32'(rdq[1:0]), 32'h0000_0002);
        chkIn(3, 8'h80);
        chk(32'(irq), 32'h0000_0001);
        apb(1'b1, UBD_IDX_IMASK, 32'h0000_0000);
        repeat (2) @(posedge mclk);
        chk(32'(irq), 32'h0000_0000);
        apb(1'b1, UBD_IDX_IMASK, 32'h0000_0007);
        repeat (2) @(posedge mclk);
        chk(32'(irq), 32'h0000_0001);
        apb(1'b1, UBD_IDX_IST, 32'h0000_0007);
        repeat (2) @(posedge mclk);
        chk(32'(irq), 32'h0000_0000);
        apb(1'b1, UBD_IDX_TMO, 32'h0000_0088);
        apb(1'b0, UBD_IDX_TMO);
        chk(32'(rdq[1]), 32'h0000_0001);
        apb(1'b1, UBD_IDX_TMO, 32'h0000_008a);
        apb(1'b0, UBD_IDX_TMO);
        chk(32'(rdq[1]), 32'h0000_0000);
        ubd_far_model_i.rxByte(8'h55, 1'b0);
        apb(1'b0, UBD_IDX_TMO);
        chk(32'(rdq[1:0]), 32'h0000_0002);
        apb(1'b0, UBD_IDX_IST);
        chk(rdq, 32'h0000_0004);
        apb(1'b0, UBD_IDX_CTRL);
        chk(32'(rdq[0]), 32'h0000_0001);
        $display("test in done");
    endtask
    task tOut();
        apb(1'b1, UBD_IDX_IST, 32'h0000_0007);
        apb(1'b1, UBD_IDX_TMO, 32'h0000_0003);
        apb(1'b1, UBD_IDX_CTRL, 32'h0000_0007);
        ubd_far_model_i.hostPkt(64, 8'h00);
        ubd_far_model_i.hostPkt(5, 8'h40);
        waitQ(69, 1'b1);
        for (int i = 0; i < 69; i++) chk(32'(ubd_far_model_i.txQ.pop_front()), i);
        apb(1'b0, UBD_IDX_TMO);
        chk(32'({rdq[8], rdq[1]}), 32'h0000_0002);
        apb(1'b0, UBD_IDX_IST);
        chk(32'(rdq[1]), 32'h0000_0001);
        chk(32'(irq), 32'h0000_0001);
        apb(1'b1, UBD_IDX_TMO, 32'h0000_0080);
        sof();
        apb(1'b0, UBD_IDX_TMO);
        chk(32'(rdq[1:0]), 32'h0000_0002);
        apb(1'b1, UBD_IDX_CTRL, 32'h0000_0000);
        $display("test out done");
    endtask
    task giveVerdict();
        $display("checks %0d mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        {psel, penable, pwrite, sofPulse, resetn} = 5'b00000;
        paddr = '0;
        pwdata = 32'h0000_0000;
        failCount = 0;
        nTests = 0;
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        tRegs();
        tIn();
        tOut();
        giveVerdict();
    end
    initial
    begin
        #200000;
        failCount++;
        $display("mismatch at %0t: watchdog", $time);
        giveVerdict();
    end
endmodule // usb_uart_bulk_dma_tb_top
bind ubd_top ubd_top_sva #(.BIT_CLKS(BIT_CLKS)) ubd_top_sva_i (.mclk(mclk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serialOutputLine(serialOutputLine),
    .usbInData(usbInData), .usbInValid(usbInValid), .usbInLast(usbInLast),
    .usbInTake(usbInTake));
